/* File: hdl/freq_ramp.sv */
// Purpose: Move the output frequency toward a target one count at a time.
// Assumes: Rates are clock cycles per 0.01 Hz minus one, set from acc/dec time by software.
// Notes: A rate of zero moves one count per cycle.
module freq_ramp
    import updown_pkg::*;
#(
    parameter int unsigned FREQ_W = FREQ_W_DEF,
    parameter int unsigned RATE_W = RATE_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [FREQ_W-1:0] target,
    input wire logic [RATE_W-1:0] accel_cycles,
    input wire logic [RATE_W-1:0] decel_cycles,
    output logic [FREQ_W-1:0] freq_q
);
    logic [RATE_W-1:0] cnt_q;
    logic [RATE_W-1:0] interval;

    // Rising frequency uses the acceleration rate, falling the deceleration rate.
    assign interval = (freq_q < target) ? accel_cycles : decel_cycles;

    // Pace counter and output frequency.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            freq_q <= '0;
        end else if (freq_q == target) begin
            cnt_q <= '0;
        end else if (cnt_q >= interval) begin
            cnt_q <= '0;
            if (freq_q < target) begin
                freq_q <= freq_q + 1'b1;
            end else begin
                freq_q <= freq_q - 1'b1;
            end
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // The output never jumps by more than one count per cycle.
    ramp_slew_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
        (freq_q == $past(freq_q)) || (freq_q == $past(freq_q) + 1'b1)
        || (freq_q == $past(freq_q) - 1'b1))
        else $error("Ramp output moved by more than one count.");
endmodule // freq_ramp

/* File: hdl/terminal_sync.sv */
// Purpose: Synchronise terminal inputs and produce level, rise and fall.
// Assumes: One clock; raw inputs may change at any edge.
// Notes: Edge outputs are one-cycle pulses taken after the second stage.
module terminal_sync
    import updown_pkg::*;
#(
    parameter int unsigned N = TERMS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [N-1:0] raw,
    output logic [N-1:0] lvl_q,
    output logic [N-1:0] rise_q,
    output logic [N-1:0] fall_q
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;

    // Two-stage synchroniser plus edge register for each terminal.
    for (genvar i = 0; i < N; i++) begin : g_term
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
                lvl_q[i] <= 1'b0;
                rise_q[i] <= 1'b0;
                fall_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= raw[i]; // RULE22
                sync_q[i] <= meta_q[i];
                lvl_q[i] <= sync_q[i];
                rise_q[i] <= sync_q[i] & ~lvl_q[i]; // RULE22
                fall_q[i] <= ~sync_q[i] & lvl_q[i];
            end
        end

        // A rise pulse always comes with a new high level in the same cycle.
        rise_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE22
            rise_q[i] |-> lvl_q[i] && !$past(lvl_q[i]))
            else $error("Rise pulse without a new high level.");
    end
endmodule // terminal_sync

/* File: hdl/updown_frequency_command.sv */
// Purpose: Turn terminal inputs into an up/down frequency command and 3-wire run.
// Assumes: Configuration ports are static while the drive is running.
// Notes: Terminals four and five are honoured only on advanced I/O builds.
module updown_frequency_command
    import updown_pkg::*;
#(
    parameter int unsigned FREQ_W = FREQ_W_DEF,
    parameter int unsigned RATE_W = RATE_W_DEF,
    parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic advanced_io,
    input wire logic [SRC_W-1:0] freq_src_sel,
    input wire logic [FN_W-1:0] term3_function_sel,
    input wire logic [FN_W-1:0] term4_function_sel,
    input wire logic [FN_W-1:0] term5_function_sel,
    input wire logic input_terminal_three,
    input wire logic input_terminal_four,
    input wire logic input_terminal_five,
    input wire logic updown_save_enable,
    input wire logic [1:0] updown_mode_sel,
    input wire logic [FREQ_W-1:0] updown_step_size,
    input wire logic [FREQ_W-1:0] max_freq,
    input wire logic [FREQ_W-1:0] min_freq,
    input wire logic upper_limit_en,
    input wire logic [FREQ_W-1:0] upper_limit,
    input wire logic lower_limit_en,
    input wire logic [FREQ_W-1:0] lower_limit,
    input wire logic [RATE_W-1:0] accel_cycles,
    input wire logic [RATE_W-1:0] decel_cycles,
    input wire logic run_cmd,
    output logic updown_active_q,
    output logic [FREQ_W-1:0] freq_cmd_q,
    output logic [FREQ_W-1:0] saved_updown_freq_q,
    output logic step_busy_q,
    output logic run_out_q
);
    // Which enabled terminals carry a given function code.
    function automatic logic [TERMS-1:0] fn_hits(
        input logic [FN_W-1:0] c3,
        input logic [FN_W-1:0] c4,
        input logic [FN_W-1:0] c5,
        input logic [TERMS-1:0] en,
        input logic [FN_W-1:0] fn
    );
        fn_hits = {c5 == fn, c4 == fn, c3 == fn} & en;
    endfunction

    logic [TERMS-1:0] term_en;
    logic [TERMS-1:0] lvl;
    logic [TERMS-1:0] rise;
    logic [TERMS-1:0] fall;
    logic [TERMS-1:0] up_sel;
    logic [TERMS-1:0] down_sel;
    logic [TERMS-1:0] clr_sel;
    logic [TERMS-1:0] w3_sel;
    logic up_lvl;
    logic down_lvl;
    logic up_rise;
    logic down_rise;
    logic ud_fall;
    logic clr_rise;
    logic wire3_cfg;
    logic wire3_lvl;
    logic active;
    logic held;
    ud_mode_t mode;
    ud_state_t ud_state_q;
    ud_state_t ud_state_d;
    logic dir_up_q;
    logic [HOLD_CNT_W-1:0] hold_cnt_q;
    logic [FREQ_W-1:0] target_q;
    logic [FREQ_W-1:0] hi_lim;
    logic [FREQ_W-1:0] lo_lim;
    logic [FREQ_W:0] step_sum;
    logic [FREQ_W-1:0] step_up_val;
    logic [FREQ_W-1:0] step_dn_val;
    logic busy;
    logic step_go;
    logic run_d;
    logic stop_evt;
    logic save_evt;
    logic clr_go;

    // Standard I/O builds expose only terminal three of this group.
    assign term_en = {advanced_io, advanced_io, 1'b1}; // RULE18

    terminal_sync #(
        .N(TERMS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw({input_terminal_five, input_terminal_four, input_terminal_three}),
        .lvl_q(lvl),
        .rise_q(rise),
        .fall_q(fall)
    );

    // Decode the terminal function codes.
    assign up_sel = fn_hits(term3_function_sel, term4_function_sel, term5_function_sel,
        term_en, FN_UP); // RULE2
    assign down_sel = fn_hits(term3_function_sel, term4_function_sel, term5_function_sel,
        term_en, FN_DOWN); // RULE2
    assign clr_sel = fn_hits(term3_function_sel, term4_function_sel, term5_function_sel,
        term_en, FN_CLEAR); // RULE3
    assign w3_sel = fn_hits(term3_function_sel, term4_function_sel, term5_function_sel,
        term_en, FN_WIRE3); // RULE19

    // Combine terminals of the same function.
    assign up_lvl = |(up_sel & lvl);
    assign down_lvl = |(down_sel & lvl);
    assign up_rise = |(up_sel & rise);
    assign down_rise = |(down_sel & rise);
    assign ud_fall = |((up_sel | down_sel) & fall);
    assign clr_rise = |(clr_sel & rise);
    assign wire3_cfg = |w3_sel;
    assign wire3_lvl = |(w3_sel & lvl);
    assign held = up_lvl | down_lvl;

    // Up/down logic only commands the frequency when selected as the source.
    assign active = (freq_src_sel == SRC_UPDOWN); // RULE1

    // Unknown mode values fall back to the continuous default.
    always_comb begin
        case (updown_mode_sel)
            MODE_STEP: mode = MODE_STEP;
            MODE_BOTH: mode = MODE_BOTH;
            default: mode = MODE_CONT; // RULE8
        endcase
    end

    // Limits: configured limit if enabled, otherwise maximum and minimum.
    assign hi_lim = upper_limit_en ? upper_limit : max_freq; // RULE9
    assign lo_lim = lower_limit_en ? lower_limit : min_freq; // RULE10

    // Saturating step arithmetic against the active limits.
    assign step_sum = {1'b0, target_q} + {1'b0, updown_step_size};
    assign step_up_val = (step_sum > {1'b0, hi_lim}) ? hi_lim : step_sum[FREQ_W-1:0];
    assign step_dn_val = ({1'b0, target_q} < {1'b0, lo_lim} + {1'b0, updown_step_size})
        ? lo_lim : target_q - updown_step_size;

    // A step is still in flight while the ramp has not reached the target.
    assign busy = (freq_cmd_q != target_q);
    assign step_go = active && (mode != MODE_CONT) && (up_rise || down_rise) && !busy;

    // Next state of the up/down engine.
    always_comb begin
        ud_state_d = ud_state_q;
        case (ud_state_q)
            UD_IDLE: begin
                if (active && mode == MODE_CONT && held) begin
                    ud_state_d = UD_CONT; // RULE8
                end else if (active && mode != MODE_CONT && (up_rise || down_rise)) begin
                    ud_state_d = UD_STEP;
                end
            end
            UD_STEP: begin
                if (!active || !held) begin
                    ud_state_d = UD_IDLE;
                end else if (mode == MODE_BOTH && hold_cnt_q >= HOLD_CYCLES - 1) begin
                    ud_state_d = UD_CONT; // RULE15
                end
            end
            UD_CONT: begin
                if (!active || !held) begin
                    ud_state_d = UD_IDLE;
                end
            end
            default: ud_state_d = UD_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ud_state_q <= UD_IDLE;
        end else begin
            ud_state_q <= ud_state_d;
        end
    end

    // Direction of the current press; increase wins if both rise together.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_up_q <= 1'b1;
        end else if (ud_state_q == UD_IDLE && ud_state_d != UD_IDLE) begin
            dir_up_q <= up_lvl;
        end
    end

    // Counts how long the input has been held in step state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_q <= '0;
        end else if (ud_state_q != UD_STEP) begin
            hold_cnt_q <= '0;
        end else if (hold_cnt_q < HOLD_CYCLES - 1) begin
            hold_cnt_q <= hold_cnt_q + 1'b1; // RULE15
        end
    end

    // Target frequency for the ramp.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= '0;
        end else if (!active) begin
            target_q <= target_q; // RULE1
        end else if (ud_state_d == UD_CONT) begin
            // The direction register lags one edge on entry from idle, so use the level there.
            target_q <= (ud_state_q == UD_IDLE ? up_lvl : dir_up_q) ? hi_lim : lo_lim; // RULE9 RULE10
        end else if (ud_state_q == UD_CONT) begin
            target_q <= freq_cmd_q; // Stop where the ramp stands on release.
        end else if (step_go) begin
            target_q <= up_rise ? step_up_val : step_dn_val; // RULE11 RULE16 RULE17
        end
    end

    freq_ramp #(
        .FREQ_W(FREQ_W),
        .RATE_W(RATE_W)
    ) u_ramp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .target(target_q),
        .accel_cycles(accel_cycles), // RULE14
        .decel_cycles(decel_cycles),
        .freq_q(freq_cmd_q)
    );

    // 3-wire latch: run pulse sets, dropping the 3-wire input releases.
    always_comb begin
        if (!wire3_cfg) begin
            run_d = run_cmd;
        end else if (!wire3_lvl) begin
            run_d = 1'b0; // RULE23
        end else if (run_cmd) begin
            run_d = 1'b1; // RULE20
        end else begin
            run_d = run_out_q; // RULE20
        end
    end

    // Run output register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_out_q <= 1'b0;
        end else begin
            run_out_q <= run_d;
        end
    end

    // Save and clear events; a release seen while stopped is not saved, so a stop
    // during a press keeps the older value.
    assign stop_evt = run_out_q && !run_d;
    assign save_evt = active && (updown_save_enable == SAVE_ON)
        && ((ud_fall && run_out_q) || (stop_evt && !held)); // RULE5 RULE12 RULE13 RULE16
    assign clr_go = active && run_out_q && clr_rise && !held; // RULE6 RULE7

    // Saved frequency; a clear wins over a save in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_updown_freq_q <= '0;
        end else if (clr_go) begin
            saved_updown_freq_q <= '0; // RULE6
        end else if (save_evt) begin
            saved_updown_freq_q <= freq_cmd_q; // RULE4 RULE5 RULE12
        end
    end

    // Status outputs.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            updown_active_q <= 1'b0;
            step_busy_q <= 1'b0;
        end else begin
            updown_active_q <= active;
            step_busy_q <= busy && (ud_state_q != UD_CONT);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Deselected source freezes the target.
    src_gate_a: assert property (!active |=> target_q == $past(target_q)) // RULE1
        else $error("Target moved while up/down is not the source.");

    // Mode 0 with increase held heads for the upper bound.
    cont_up_a: assert property ( // RULE9
        (ud_state_q == UD_IDLE && active && mode == MODE_CONT && up_lvl)
        |=> ud_state_q == UD_CONT && dir_up_q && target_q == $past(hi_lim))
        else $error("Continuous increase did not aim at the upper bound.");

    // Mode 0 decrease heads for the lower bound.
    cont_dn_a: assert property ( // RULE10
        (ud_state_q == UD_CONT && !dir_up_q && active && held) |=> target_q == $past(lo_lim))
        else $error("Continuous decrease did not aim at the lower bound.");

    // Accepted increase edge adds one step.
    step_add_a: assert property ( // RULE11
        (step_go && up_rise && ud_state_q != UD_CONT && ud_state_d != UD_CONT)
        |=> target_q == $past(step_up_val))
        else $error("Increase edge did not add one step.");

    // Edge during an unfinished step leaves the target alone.
    step_ignore_a: assert property ( // RULE16
        (active && ud_state_q == UD_STEP && ud_state_d == UD_STEP && busy)
        |=> target_q == $past(target_q))
        else $error("Edge accepted while a step was still ramping.");

    // Release with saving on stores the present frequency.
    save_fall_a: assert property ( // RULE12
        (active && updown_save_enable && run_out_q && ud_fall && !clr_go)
        |=> saved_updown_freq_q == $past(freq_cmd_q))
        else $error("Frequency not saved on release.");

    // Stop while an input is held keeps the earlier saved value.
    stop_keep_a: assert property ( // RULE13
        (stop_evt && held && !ud_fall && !clr_go)
        |=> saved_updown_freq_q == $past(saved_updown_freq_q))
        else $error("Saved value changed on stop with input held.");

    // Clear is refused while increase or decrease is active.
    clear_block_a: assert property ( // RULE7
        (clr_rise && held && !save_evt) |=> $stable(saved_updown_freq_q))
        else $error("Clear acted while an up or down input was on.");

    // Accepted clear empties the saved value.
    clear_save_a: assert property (clr_go |=> saved_updown_freq_q == '0) // RULE6
        else $error("Clear did not erase the saved value.");

    // Mode 2 hold past the limit goes continuous.
    hold_cont_a: assert property ( // RULE15
        (active && held && mode == MODE_BOTH && ud_state_q == UD_STEP
        && hold_cnt_q == HOLD_CYCLES - 1) |=> ud_state_q == UD_CONT)
        else $error("Long hold did not switch to continuous change.");

    // Run pulse stays latched after the button is released.
    run_latch_a: assert property ( // RULE20
        (wire3_cfg && wire3_lvl && run_cmd) ##1 (wire3_cfg && wire3_lvl && !run_cmd)
        |=> run_out_q)
        else $error("3-wire run command was not latched.");

    // Dropping the 3-wire input releases the latch.
    run_release_a: assert property ((wire3_cfg && !wire3_lvl) |=> !run_out_q) // RULE23
        else $error("3-wire latch not released.");
endmodule // updown_frequency_command

/* File: hdl/updown_pkg.sv */
// Purpose: Shared constants and types for the up/down frequency command block.
// Assumes: 100 MHz ref_clk; frequencies are unsigned counts of 0.01 Hz.
// Notes: Function codes and mode values are the parameter encodings seen by software.
// Function
// RULE1 - Up/down drives command only when source is 10.
// RULE2 - Terminal code 15 raises, code 16 lowers.
// RULE3 - Terminal code 25 clears the saved frequency.
// RULE4 - Save option: 0 off by default, 1 on.
// RULE5 - With saving on, store frequency before stopping.
// RULE6 - Clear input erases saved value while running.
// RULE7 - Clear ignored while increase or decrease active.
// RULE8 - Mode 0, 1, 2; mode 0 continuous within limits.
// RULE9 - Mode 0 increase ramps toward upper bound.
// RULE10 - Mode 0 decrease ramps toward lower bound.
// RULE11 - Mode 1 rising edge steps by step size.
// RULE12 - Mode 1 stores frequency on input fall.
// RULE13 - Stop during held input keeps previous save.
// RULE14 - Step changes use the mode 0 ramp rates.
// RULE15 - Mode 2 steps, then continuous after 3 s.
// RULE16 - Edge during unfinished step ignored; save at release.
// RULE17 - Step size from zero to maximum, default zero.
// RULE18 - Standard I/O offers three terminals, advanced more.
// RULE19 - Terminal code 17 is the 3-wire input.
// RULE20 - 3-wire latches a momentary run command.
// RULE21 - Operator holds 3-wire pulses at least 50 ms.
// RULE22 - Synchronise and edge-detect every terminal input.
// RULE23 - Dropping the 3-wire input releases the latch.
package updown_pkg;
    localparam int unsigned FREQ_W_DEF = 16;
    localparam int unsigned RATE_W_DEF = 24;
    localparam int unsigned TERMS = 3;
    localparam int unsigned FN_W = 5;
    localparam int unsigned SRC_W = 4;
    localparam logic [SRC_W-1:0] SRC_UPDOWN = 4'ha;
    localparam logic [FN_W-1:0] FN_UP = 5'h0f;
    localparam logic [FN_W-1:0] FN_DOWN = 5'h10;
    localparam logic [FN_W-1:0] FN_WIRE3 = 5'h11;
    localparam logic [FN_W-1:0] FN_CLEAR = 5'h19;
    localparam logic SAVE_OFF = 1'b0;
    localparam logic SAVE_ON = 1'b1;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned HOLD_TIME_MS = 3000;
    localparam int unsigned PULSE_MIN_MS = 50;
    localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned PULSE_MIN_CYCLES = PULSE_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned HOLD_CNT_W = 32;

    // Up/down mode encodings.
    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_STEP = 2'b01,
        MODE_BOTH = 2'b10
    } ud_mode_t;

    // Activity of the up/down engine.
    typedef enum logic [1:0] {
        UD_IDLE = 2'b00,
        UD_STEP = 2'b01,
        UD_CONT = 2'b10
    } ud_state_t;
endpackage

/* File: verification/operator_panel.sv */
// Purpose: Behavioural push-button panel wired to the three input terminals.
// Assumes: Buttons are sampled by the block on ref_clk; a released line pulls low.
// Notes: Every press made with the press task is stretched to at least PULSE_CYC cycles; set_level is not.
module operator_panel #(
    parameter int PULSE_CYC = 8
) (
    input wire logic ref_clk,
    output logic [2:0] buttons
);
    timeunit 1ns;
    timeprecision 1ps;

    // All buttons start released.
    initial buttons = 3'h0;

    // Moves one button to a level just after a falling edge.
    task automatic set_level(input int idx, input logic v);
        @(negedge ref_clk);
        buttons[idx] = v;
    endtask

    // Presses one button for n cycles, never shorter than the minimum pulse.
    task automatic press(input int idx, input int n);
        set_level(idx, 1'b1);
        repeat ((n < PULSE_CYC) ? PULSE_CYC : n) @(negedge ref_clk);
        buttons[idx] = 1'b0;
    endtask
endmodule // operator_panel

/* File: verification/updown_frequency_command_tb.sv */
// Purpose: Self-checking bench for the up/down frequency command block.
// Assumes: Inputs change on the falling edge; terminal 3 clears, 4 raises, 5 lowers.
// Notes: The compound-mode hold time is shortened to 50 cycles.
module updown_frequency_command_tb
    import updown_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic advanced_io = 1'b1;
    logic updown_save_enable = 1'b0;
    logic upper_limit_en = 1'b0;
    logic lower_limit_en = 1'b0;
    logic run_cmd = 1'b1;
    logic [SRC_W-1:0] freq_src_sel = 4'h0;
    logic [FN_W-1:0] term3_function_sel = FN_CLEAR;
    logic [FN_W-1:0] term4_function_sel = FN_UP;
    logic [FN_W-1:0] term5_function_sel = FN_DOWN;
    logic [1:0] updown_mode_sel = 2'h1;
    logic [15:0] updown_step_size = 16'h0064;
    logic [15:0] max_freq = 16'h03e8;
    logic [15:0] min_freq = 16'h0000;
    logic [15:0] upper_limit = 16'h01f4;
    logic [15:0] lower_limit = 16'h00c8;
    logic [23:0] accel_cycles = 24'h000000;
    logic [23:0] decel_cycles = 24'h000000;
    logic [2:0] buttons;
    logic updown_active_q, step_busy_q, run_out_q;
    logic [15:0] freq_cmd_q, saved_updown_freq_q;
    int n_errors = 0;
    int n_compared = 0;

    // Free-running 100 MHz clock.
    initial forever #5 ref_clk = ~ref_clk;

    updown_frequency_command #(.HOLD_CYCLES(50)) dut_u (
        .ref_clk, .rst_n, .advanced_io, .freq_src_sel,
        .term3_function_sel, .term4_function_sel, .term5_function_sel,
        .input_terminal_three(buttons[0]), .input_terminal_four(buttons[1]),
        .input_terminal_five(buttons[2]), .updown_save_enable, .updown_mode_sel,
        .updown_step_size, .max_freq, .min_freq, .upper_limit_en, .upper_limit,
        .lower_limit_en, .lower_limit, .accel_cycles, .decel_cycles, .run_cmd,
        .updown_active_q, .freq_cmd_q, .saved_updown_freq_q, .step_busy_q, .run_out_q
    );

    operator_panel #(.PULSE_CYC(8)) panel_u (.ref_clk, .buttons);

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits, bounded, for a step ramp to finish, then lets outputs settle.
    task automatic settle();
        int i;
        repeat (6) @(negedge ref_clk);
        for (i = 0; i < 3000 && step_busy_q !== 1'b0; i++) @(negedge ref_clk);
        if (i == 3000) n_errors++;
        repeat (6) @(negedge ref_clk);
    endtask

    // Presses one button for n cycles and waits for the result.
    task automatic hold(input int idx, input int n);
        panel_u.press(idx, n);
        settle();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #300000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence of tests.
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        check(freq_cmd_q, 16'h0000);
        check(saved_updown_freq_q, 16'h0000);
        hold(1, 20);
        check(freq_cmd_q, 16'h0000);
        check(16'(updown_active_q), 16'h0000);
        freq_src_sel = SRC_UPDOWN;
        repeat (3) @(negedge ref_clk);
        check(16'(updown_active_q), 16'h0001);
        $display("test source_select done");
        updown_save_enable = SAVE_ON;
        hold(1, 120);
        check(freq_cmd_q, 16'h0064);
        check(saved_updown_freq_q, 16'h0064);
        hold(1, 20);
        hold(2, 20);
        check(freq_cmd_q, 16'h0064);
        accel_cycles = 24'h000003;
        panel_u.press(1, 10);
        panel_u.press(1, 10);
        repeat (150) @(negedge ref_clk);
        check(16'(freq_cmd_q < 16'h00c8), 16'h0001);
        check(16'(step_busy_q), 16'h0001);
        settle();
        check(freq_cmd_q, 16'h00c8);
        accel_cycles = 24'h000000;
        $display("test step_mode done");
        hold(0, 20);
        check(saved_updown_freq_q, 16'h0000);
        hold(1, 120);
        updown_save_enable = SAVE_OFF;
        panel_u.set_level(1, 1'b1);
        hold(0, 20);
        panel_u.set_level(1, 1'b0);
        settle();
        check(saved_updown_freq_q, 16'h012c);
        check(freq_cmd_q, 16'h0190);
        updown_save_enable = SAVE_ON;
        panel_u.set_level(1, 1'b1);
        settle();
        run_cmd = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(saved_updown_freq_q, 16'h012c);
        panel_u.set_level(1, 1'b0);
        repeat (8) @(negedge ref_clk);
        check(saved_updown_freq_q, 16'h012c);
        run_cmd = 1'b1;
        settle();
        hold(0, 20);
        run_cmd = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(saved_updown_freq_q, 16'h01f4);
        run_cmd = 1'b1;
        $display("test clear_and_save done");
        updown_mode_sel = 2'h0;
        upper_limit_en = 1'b1;
        lower_limit_en = 1'b1;
        hold(2, 700);
        check(freq_cmd_q, 16'h00c8);
        hold(1, 700);
        check(freq_cmd_q, 16'h01f4);
        hold(2, 700);
        check(freq_cmd_q, 16'h00c8);
        updown_mode_sel = 2'h2;
        updown_step_size = 16'h000a;
        hold(1, 20);
        check(freq_cmd_q, 16'h00d2);
        hold(1, 400);
        check(freq_cmd_q, 16'h01f4);
        advanced_io = 1'b0;
        hold(2, 20);
        check(freq_cmd_q, 16'h01f4);
        advanced_io = 1'b1;
        $display("test continuous_and_compound done");
        term5_function_sel = FN_WIRE3;
        run_cmd = 1'b0;
        panel_u.set_level(2, 1'b1);
        repeat (6) @(negedge ref_clk);
        run_cmd = 1'b1;
        repeat (10) @(negedge ref_clk);
        run_cmd = 1'b0;
        repeat (6) @(negedge ref_clk);
        check(16'(run_out_q), 16'h0001);
        panel_u.set_level(2, 1'b0);
        repeat (6) @(negedge ref_clk);
        check(16'(run_out_q), 16'h0000);
        $display("test three_wire done");
        tally_and_finish();
    end
endmodule // updown_frequency_command_tb
